//--- rtl/periph_flag_pkg.sv
package periph_flag_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFS_FLAGS_ONE     = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_TWO     = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS    = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_CCP_MODE      = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_COMPARE_VALUE = 6'h14;

    // bit positions in peripheral_flags_one
    localparam int unsigned BIT_TIMER_A_OVF   = 0;
    localparam int unsigned BIT_TIMER_B_MATCH = 1;
    localparam int unsigned BIT_CAPT_COMPARE  = 2;
    localparam int unsigned BIT_TX_EMPTY      = 4;
    localparam int unsigned BIT_RX_FULL       = 5;
    localparam int unsigned BIT_CONV_DONE     = 6;

    // bit positions in peripheral_flags_two
    localparam int unsigned BIT_VOLT_DETECT = 2;
    localparam int unsigned BIT_USB_REQUEST = 5;
    localparam int unsigned BIT_OSC_FAIL    = 7;

    // implemented bits, and the bits software may write
    localparam logic [7:0] FLAGS_ONE_IMPL = 8'h77;
    localparam logic [7:0] FLAGS_ONE_WR   = 8'h47;
    localparam logic [7:0] FLAGS_TWO_IMPL = 8'hA4;
    localparam logic [7:0] FLAGS_TWO_WR   = 8'hA4;

    // reset values
    localparam logic [7:0]  RST_FLAGS_ONE     = 8'h00;
    localparam logic [7:0]  RST_FLAGS_TWO     = 8'h00;
    localparam logic [15:0] RST_IRQ_STATUS    = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK      = 16'h0000;
    localparam logic [15:0] RST_COMPARE_VALUE = 16'h0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // capture/compare unit mode, Gray ordered
    typedef enum logic [1:0] {
        CCP_CAPTURE = 2'h0,
        CCP_COMPARE = 2'h1,
        CCP_PWM     = 2'h3,
        CCP_OFF     = 2'h2
    } ccp_mode_e;

    localparam ccp_mode_e RST_CCP_MODE = CCP_OFF;

endpackage : periph_flag_pkg

//--- rtl/ccp_event.sv
`timescale 1ns/10ps
module ccp_event
    import periph_flag_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire ccp_mode_e   mode_in,
    input  wire logic [15:0] timer_a_count_in,
    input  wire logic [15:0] compare_value_in,
    input  wire logic        capture_edge_in,
    output logic             event_out
);

    typedef struct packed {
        logic match;
        logic event_hit;
    } ccp_state_s;

    ccp_state_s s_q;
    ccp_state_s s_d;
    logic       match_now;

    assign match_now = (timer_a_count_in == compare_value_in);

    always_comb begin
        s_d = s_q;
        s_d.match = match_now;
        s_d.event_hit = 1'b0;
        unique case (mode_in)
            CCP_CAPTURE: s_d.event_hit = capture_edge_in;
            // only entering the match fires, so a stalled timer sitting on
            // the compare value does not keep re-raising the flag
            CCP_COMPARE: s_d.event_hit = match_now && !s_q.match;
            CCP_PWM:     s_d.event_hit = 1'b0;
            CCP_OFF:     s_d.event_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign event_out = s_q.event_hit;

endmodule : ccp_event

//--- rtl/peripheral_irq_flag_regs.sv
// Summary of operation
// - flags set regardless of any enable bit
// - flags split over two 8-bit registers
// - unimplemented bits read zero, ignore writes
// - conversion done sets sticky flag bit 6
// - bit 5 follows rx buffer full, read-only
// - bit 4 follows tx buffer empty, read-only
// - bit 2 latches capture or compare event
// - compare mode sets flag when timer reaches value
// - bit 1 latches timer b period match
// - bit 0 latches timer a overflow
// - flags two bit 2 set on voltage event
`timescale 1ns/10ps
module peripheral_irq_flag_regs
    import periph_flag_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // AXI4-Lite slave
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic [2:0]        s_axi_awprot_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    output logic [1:0]             s_axi_bresp_out,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic [2:0]        s_axi_arprot_in,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    // peripheral events, one-cycle pulses
    input  wire logic              conversion_done_in,
    input  wire logic              timer_b_period_match_in,
    input  wire logic              timer_a_overflow_in,
    input  wire logic              osc_fail_in,
    input  wire logic              usb_request_in,
    input  wire logic              voltage_detect_in,
    input  wire logic              capture_edge_in,
    // peripheral levels
    input  wire logic              serial_rx_full_in,
    input  wire logic              serial_tx_empty_in,
    input  wire logic [15:0]       timer_a_count_in,
    // to the core
    output logic [7:0]             peripheral_flags_one_out,
    output logic [7:0]             peripheral_flags_two_out,
    output logic                   irq_out
);

    typedef struct packed {
        logic [7:0]        flags_one;
        logic [7:0]        flags_two;
        logic [15:0]       irq_status;
        logic [15:0]       irq_mask;
        ccp_mode_e         ccp_mode;
        logic [15:0]       compare_value;
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              irq;
    } regs_state_s;

    localparam regs_state_s RST_STATE = '{
        flags_one:     RST_FLAGS_ONE,
        flags_two:     RST_FLAGS_TWO,
        irq_status:    RST_IRQ_STATUS,
        irq_mask:      RST_IRQ_MASK,
        ccp_mode:      RST_CCP_MODE,
        compare_value: RST_COMPARE_VALUE,
        aw_got:        1'b0,
        aw_addr:       '0,
        w_got:         1'b0,
        w_data:        32'h0000_0000,
        w_strb:        4'h0,
        awready:       1'b1,
        wready:        1'b1,
        bvalid:        1'b0,
        bresp:         RESP_OKAY,
        arready:       1'b1,
        rvalid:        1'b0,
        rdata:         32'h0000_0000,
        rresp:         RESP_OKAY,
        irq:           1'b0
    };

    regs_state_s s_q;
    regs_state_s s_d;
    logic        ccp_hit;

    // low bits of the address are ignored: every register is one word
    function automatic logic [ADDR_W-1:0] word_addr(
        input logic [ADDR_W-1:0] addr
    );
        return {addr[ADDR_W-1:2], 2'h0};
    endfunction : word_addr

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] a;
        a = word_addr(addr);
        return (a == OFS_FLAGS_ONE) || (a == OFS_FLAGS_TWO) ||
               (a == OFS_IRQ_STATUS) || (a == OFS_IRQ_MASK) ||
               (a == OFS_CCP_MODE) || (a == OFS_COMPARE_VALUE);
    endfunction : is_mapped

    // unmapped offsets answer with an error instead of silently aliasing
    function automatic logic [1:0] bus_resp(input logic [ADDR_W-1:0] addr);
        return is_mapped(addr) ? RESP_OKAY : RESP_SLVERR;
    endfunction : bus_resp

    function automatic logic [31:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input regs_state_s       s
    );
        logic [ADDR_W-1:0] a;
        logic [31:0]       w;
        a = word_addr(addr);
        w = 32'h0000_0000;
        unique case (a)
            OFS_FLAGS_ONE:     w[7:0] = s.flags_one & FLAGS_ONE_IMPL;
            OFS_FLAGS_TWO:     w[7:0] = s.flags_two & FLAGS_TWO_IMPL;
            OFS_IRQ_STATUS:    w[15:0] = s.irq_status;
            OFS_IRQ_MASK:      w[15:0] = s.irq_mask;
            OFS_CCP_MODE:      w[1:0] = s.ccp_mode;
            OFS_COMPARE_VALUE: w[15:0] = s.compare_value;
            default:           w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    // byte lane mask from strobes, limited to the low two lanes
    // the upper lanes and the protection bits carry no meaning here
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    function automatic logic [15:0] merge_lanes(
        input logic [15:0] old_word,
        input logic [15:0] wr_data,
        input logic [15:0] lanes
    );
        return (old_word & ~lanes) | (wr_data & lanes);
    endfunction : merge_lanes

    // software stores into the writable bits; a hardware set in the same
    // cycle wins over a software clear so no event is lost
    function automatic logic [7:0] merge_flags(
        input logic [7:0] old_flags,
        input logic [7:0] wr_data,
        input logic [7:0] wr_mask,
        input logic [7:0] set_mask,
        input logic [7:0] impl_mask
    );
        return ((old_flags & ~wr_mask) | (wr_data & wr_mask) | set_mask) &
               impl_mask;
    endfunction : merge_flags

    function automatic logic [7:0] rising(
        input logic [7:0] now_bits,
        input logic [7:0] was_bits
    );
        return now_bits & ~was_bits;
    endfunction : rising

    ccp_event u_ccp_event (
        .clk_in           (clk_in),
        .rst_in           (rst_in),
        .mode_in          (s_q.ccp_mode),
        .timer_a_count_in (timer_a_count_in),
        .compare_value_in (s_q.compare_value),
        .capture_edge_in  (capture_edge_in),
        .event_out        (ccp_hit)
    );

    always_comb begin
        logic              wr_fire;
        logic [ADDR_W-1:0] wa;
        logic [15:0]       lanes;
        logic [7:0]        set_one;
        logic [7:0]        set_two;
        logic [7:0]        wr_one;
        logic [7:0]        wr_two;
        logic [15:0]       events;
        logic [15:0]       w1c;
        logic              aw_take;
        logic              w_take;
        logic              b_take;
        logic              ar_take;
        logic              r_take;

        aw_take = s_q.awready && s_axi_awvalid_in;
        w_take  = s_q.wready && s_axi_wvalid_in;
        b_take  = s_q.bvalid && s_axi_bready_in;
        ar_take = s_q.arready && s_axi_arvalid_in;
        r_take  = s_q.rvalid && s_axi_rready_in;
        wr_fire = 1'b0;
        wa      = word_addr(s_q.aw_addr);
        lanes   = lane_mask(s_q.w_strb);
        set_one = 8'h00;
        set_two = 8'h00;
        wr_one  = 8'h00;
        wr_two  = 8'h00;
        events  = 16'h0000;
        w1c     = 16'h0000;
        s_d     = s_q;

        // write channels are taken independently, in either order
        if (aw_take) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr_in;
        end
        if (w_take) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata_in;
            s_d.w_strb = s_axi_wstrb_in;
        end
        if (b_take) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            wr_fire    = 1'b1;
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = bus_resp(s_q.aw_addr);
        end

        // hardware set conditions, blind to any enable
        set_one[BIT_CONV_DONE]     = conversion_done_in;
        set_one[BIT_CAPT_COMPARE]  = ccp_hit;
        set_one[BIT_TIMER_B_MATCH] = timer_b_period_match_in;
        set_one[BIT_TIMER_A_OVF]   = timer_a_overflow_in;
        set_two[BIT_VOLT_DETECT]   = voltage_detect_in;
        set_two[BIT_USB_REQUEST]   = usb_request_in;
        set_two[BIT_OSC_FAIL]      = osc_fail_in;

        if (wr_fire && s_q.w_strb[0]) begin
            if (wa == OFS_FLAGS_ONE) begin
                wr_one = FLAGS_ONE_WR;
            end
            if (wa == OFS_FLAGS_TWO) begin
                wr_two = FLAGS_TWO_WR;
            end
        end

        s_d.flags_one = merge_flags(s_q.flags_one, s_q.w_data[7:0], wr_one,
                                    set_one, FLAGS_ONE_IMPL);
        s_d.flags_two = merge_flags(s_q.flags_two, s_q.w_data[7:0], wr_two,
                                    set_two, FLAGS_TWO_IMPL);

        // serial flags mirror the buffer state; the serial unit drops
        // the level when its buffer is read or written
        s_d.flags_one[BIT_RX_FULL]  = serial_rx_full_in;
        s_d.flags_one[BIT_TX_EMPTY] = serial_tx_empty_in;

        // status records rising flags, layout {flags_two, flags_one}
        events = {rising(s_d.flags_two, s_q.flags_two),
                  rising(s_d.flags_one, s_q.flags_one)} |
                 {set_two, set_one};

        if (wr_fire) begin
            unique case (wa)
                OFS_IRQ_STATUS: begin
                    w1c = s_q.w_data[15:0] & lanes;
                end
                OFS_IRQ_MASK: begin
                    s_d.irq_mask = merge_lanes(s_q.irq_mask,
                                               s_q.w_data[15:0], lanes);
                end
                OFS_CCP_MODE: begin
                    if (s_q.w_strb[0]) begin
                        s_d.ccp_mode = ccp_mode_e'(s_q.w_data[1:0]);
                    end
                end
                OFS_COMPARE_VALUE: begin
                    s_d.compare_value = merge_lanes(s_q.compare_value,
                                                    s_q.w_data[15:0],
                                                    lanes);
                end
                default: begin
                    w1c = 16'h0000;
                end
            endcase
        end

        s_d.irq_status = (s_q.irq_status & ~w1c) | events;
        s_d.irq        = |(s_d.irq_status & s_d.irq_mask);

        // read channel: one outstanding read, answered the next cycle
        if (r_take) begin
            s_d.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = read_word(s_axi_araddr_in, s_q);
            s_d.rresp  = bus_resp(s_axi_araddr_in);
        end

        // readies from the next state keep every output a flop
        // a write stalls both channels until its response is taken,
        // so at most one write is ever in flight
        s_d.awready = !s_d.aw_got && !s_d.bvalid;
        s_d.wready  = !s_d.w_got && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_out        = s_q.awready;
    assign s_axi_wready_out         = s_q.wready;
    assign s_axi_bvalid_out         = s_q.bvalid;
    assign s_axi_bresp_out          = s_q.bresp;
    assign s_axi_arready_out        = s_q.arready;
    assign s_axi_rvalid_out         = s_q.rvalid;
    assign s_axi_rdata_out          = s_q.rdata;
    assign s_axi_rresp_out          = s_q.rresp;
    assign peripheral_flags_one_out = s_q.flags_one;
    assign peripheral_flags_two_out = s_q.flags_two;
    assign irq_out                  = s_q.irq;

endmodule : peripheral_irq_flag_regs

//--- verif/periph_model.sv
`timescale 1ns/10ps
module periph_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [6:0]  ev_in,
    input  wire logic [3:0]  ctl_in,
    input  wire logic        run_in,
    output logic      [6:0]  ev_out,
    output logic             rx_full_out,
    output logic             tx_empty_out,
    output logic      [15:0] count_out
);
    assign ev_out = ev_in;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_full_out  <= 1'b0;
            tx_empty_out <= 1'b1;
            count_out    <= 16'h0000;
        end else begin
            // a buffer access beats new traffic in the same cycle
            if (ctl_in[1])
                rx_full_out <= 1'b0;
            else if (ctl_in[0])
                rx_full_out <= 1'b1;
            if (ctl_in[2])
                tx_empty_out <= 1'b0;
            else if (ctl_in[3])
                tx_empty_out <= 1'b1;
            if (run_in)
                count_out <= count_out + 16'h0001;
        end
    end
endmodule : periph_model

//--- verif/periph_flag_properties.sv
`timescale 1ns/10ps
module periph_flag_checker (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       s_axi_bvalid_out,
    input wire logic       conversion_done_in,
    input wire logic       timer_b_period_match_in,
    input wire logic       timer_a_overflow_in,
    input wire logic       osc_fail_in,
    input wire logic       usb_request_in,
    input wire logic       voltage_detect_in,
    input wire logic       serial_rx_full_in,
    input wire logic       serial_tx_empty_in,
    input wire logic [7:0] peripheral_flags_one_out,
    input wire logic [7:0] peripheral_flags_two_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    AST_CONV_SET:
        assert property (conversion_done_in |=> peripheral_flags_one_out[6])
        else $error("conversion flag not set");
    AST_TB_SET:
        assert property (timer_b_period_match_in
                         |=> peripheral_flags_one_out[1])
        else $error("period match flag not set");
    AST_TA_SET:
        assert property (timer_a_overflow_in |=> peripheral_flags_one_out[0])
        else $error("overflow flag not set");
    AST_OSC_SET:
        assert property (osc_fail_in |=> peripheral_flags_two_out[7])
        else $error("oscillator flag not set");
    AST_USB_SET:
        assert property (usb_request_in |=> peripheral_flags_two_out[5])
        else $error("usb flag not set");
    AST_VOLT_SET:
        assert property (voltage_detect_in |=> peripheral_flags_two_out[2])
        else $error("voltage flag not set");
    AST_RX_MIRROR:
        assert property ($past(!rst_in) |->
            peripheral_flags_one_out[5] == $past(serial_rx_full_in))
        else $error("rx flag does not follow buffer");
    AST_TX_MIRROR:
        assert property ($past(!rst_in) |->
            peripheral_flags_one_out[4] == $past(serial_tx_empty_in))
        else $error("tx flag does not follow buffer");
    AST_UNIMPL_ZERO:
        assert property ((peripheral_flags_one_out & 8'h88) == 8'h00 &&
                         (peripheral_flags_two_out & 8'h5B) == 8'h00)
        else $error("unimplemented flag bit set");
    AST_CONV_STICKY:
        assert property ($fell(peripheral_flags_one_out[6])
                         |-> $rose(s_axi_bvalid_out))
        else $error("conversion flag cleared without a write");
endmodule : periph_flag_checker

bind peripheral_irq_flag_regs periph_flag_checker i_chk (.*);

//--- verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import periph_flag_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, irq_out;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
    logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
    logic s_axi_rready_in = 1'b0, run = 1'b0;
    logic [5:0] s_axi_awaddr_in = 6'h00, s_axi_araddr_in = 6'h00;
    logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF, ctl = 4'h0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic conversion_done_in, timer_b_period_match_in, timer_a_overflow_in;
    logic osc_fail_in, usb_request_in, voltage_detect_in, capture_edge_in;
    logic serial_rx_full_in, serial_tx_empty_in;
    logic [15:0] timer_a_count_in;
    logic [7:0] peripheral_flags_one_out, peripheral_flags_two_out;
    logic [6:0] ev = 7'h00;
    int error_cnt = 0, comparisons = 0;

    always #5 clk_in = ~clk_in;

    peripheral_irq_flag_regs i_dut (.*);
    periph_model i_periph (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .ev_in       (ev),
        .ctl_in      (ctl),
        .run_in      (run),
        .ev_out      ({capture_edge_in, voltage_detect_in, usb_request_in,
                       osc_fail_in, timer_a_overflow_in,
                       timer_b_period_match_in, conversion_done_in}),
        .rx_full_out (serial_rx_full_in),
        .tx_empty_out(serial_tx_empty_in),
        .count_out   (timer_a_count_in)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_bready_in  <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out)
                break;
        end
        check({30'h0, s_axi_bresp_out}, {30'h0, er});
        s_axi_bready_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in  <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out)
                break;
        end
        check(s_axi_rdata_out, exp);
        check({30'h0, s_axi_rresp_out}, {30'h0, er});
        s_axi_rready_in <= 1'b0;
        @(posedge clk_in);
    endtask : rd

    // bits 6:0 are peripheral events, 10:7 serial buffer actions
    task automatic pulse(input logic [10:0] v);
        {ctl, ev} <= v;
        @(posedge clk_in);
        {ctl, ev} <= 11'h000;
        @(posedge clk_in);
    endtask : pulse

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial begin
        #100000;
        error_cnt++;
        $display("BAD t=%0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        rd(OFS_FLAGS_TWO, 32'h00, RESP_OKAY);
        rd(OFS_IRQ_MASK, 32'h00, RESP_OKAY);
        rd(OFS_CCP_MODE, 32'h02, RESP_OKAY);
        rd(OFS_COMPARE_VALUE, 32'h00, RESP_OKAY);
        $display("test reset values done");
        for (int i = 0; i < 6; i++)
            pulse(11'(1 << i));
        repeat (20) @(posedge clk_in);
        rd(OFS_FLAGS_ONE, 32'h53, RESP_OKAY);
        rd(OFS_FLAGS_TWO, 32'hA4, RESP_OKAY);
        check({24'h0, peripheral_flags_one_out}, 32'h53);
        check({24'h0, peripheral_flags_two_out}, 32'hA4);
        check({31'h0, irq_out}, 32'h0);
        $display("test sticky events done");
        wr(OFS_FLAGS_ONE, 32'hFF, RESP_OKAY);
        wr(OFS_FLAGS_TWO, 32'hFF, RESP_OKAY);
        rd(OFS_FLAGS_ONE, 32'h57, RESP_OKAY);
        rd(OFS_FLAGS_TWO, 32'hA4, RESP_OKAY);
        wr(OFS_FLAGS_ONE, 32'h00, RESP_OKAY);
        wr(OFS_FLAGS_TWO, 32'h00, RESP_OKAY);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        rd(OFS_FLAGS_TWO, 32'h00, RESP_OKAY);
        $display("test writes done");
        pulse(11'h080);
        rd(OFS_FLAGS_ONE, 32'h30, RESP_OKAY);
        pulse(11'h100);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        pulse(11'h200);
        rd(OFS_FLAGS_ONE, 32'h00, RESP_OKAY);
        pulse(11'h400);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        $display("test serial done");
        wr(OFS_CCP_MODE, 32'h0, RESP_OKAY);
        pulse(11'h040);
        rd(OFS_FLAGS_ONE, 32'h14, RESP_OKAY);
        wr(OFS_FLAGS_ONE, 32'h00, RESP_OKAY);
        wr(OFS_CCP_MODE, 32'h3, RESP_OKAY);
        pulse(11'h040);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        wr(OFS_COMPARE_VALUE, 32'h5, RESP_OKAY);
        wr(OFS_CCP_MODE, 32'h1, RESP_OKAY);
        wr(OFS_FLAGS_ONE, 32'h00, RESP_OKAY);
        rd(OFS_FLAGS_ONE, 32'h10, RESP_OKAY);
        run <= 1'b1;
        repeat (8) @(posedge clk_in);
        run <= 1'b0;
        rd(OFS_FLAGS_ONE, 32'h14, RESP_OKAY);
        $display("test capture compare done");
        wr(OFS_IRQ_STATUS, 32'hFFFF, RESP_OKAY);
        wr(OFS_IRQ_MASK, 32'h0001, RESP_OKAY);
        rd(OFS_IRQ_MASK, 32'h0001, RESP_OKAY);
        check({31'h0, irq_out}, 32'h0);
        pulse(11'h002);
        check({31'h0, irq_out}, 32'h0);
        pulse(11'h004);
        check({31'h0, irq_out}, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h0003, RESP_OKAY);
        wr(OFS_IRQ_STATUS, 32'h0001, RESP_OKAY);
        @(posedge clk_in);
        check({31'h0, irq_out}, 32'h0);
        $display("test interrupt done");
        rd(6'h18, 32'h0, RESP_SLVERR);
        wr(6'h18, 32'hFF, RESP_SLVERR);
        $display("test unmapped done");
        results();
    end
endmodule : testbench
